// ### rtl/rscpm_pkg.sv
package rscpm_pkg;

   // Strap positions on the narrow port address bus
   localparam int ADDR_W          = 20;
   localparam int POS_ENDIAN      = 20;
   localparam int POS_BOOT_HI     = 19;
   localparam int POS_BOOT_LO     = 18;
   localparam int POS_WCLK_HI     = 17;
   localparam int POS_WCLK_LO     = 16;
   localparam int POS_NCLK_HI     = 15;
   localparam int POS_NCLK_LO     = 14;
   localparam int POS_AUTOINIT    = 13;
   localparam int POS_CELL_EN     = 11;

   // Field encodings
   typedef enum logic [1:0] {
      RSCPM_BOOT_NONE = 2'h0,
      RSCPM_BOOT_HOST = 2'h1,
      RSCPM_BOOT_ROM8 = 2'h2,
      RSCPM_BOOT_RSVD = 2'h3
   } rscpm_boot_t;

   typedef enum logic [1:0] {
      RSCPM_CLK_EXT  = 2'h0,
      RSCPM_CLK_DIV4 = 2'h1,
      RSCPM_CLK_DIV6 = 2'h2,
      RSCPM_CLK_RSVD = 2'h3
   } rscpm_clksel_t;

   // Captured configuration
   typedef struct packed {
      logic          little_endian;
      rscpm_boot_t   boot_mode;
      rscpm_clksel_t wide_port_clock_select;
      rscpm_clksel_t narrow_port_clock_select;
      logic          eeprom_autoinit;
      logic          cell_port_enable;
   } rscpm_cfg_t;

   // Documented default values of each field
   localparam logic          RST_LITTLE_ENDIAN = 1'h1;
   localparam rscpm_boot_t   RST_BOOT          = RSCPM_BOOT_ROM8;
   localparam rscpm_clksel_t RST_WCLK          = RSCPM_CLK_EXT;
   localparam rscpm_clksel_t RST_NCLK          = RSCPM_CLK_EXT;
   localparam logic          RST_AUTOINIT      = 1'h0;
   localparam logic          RST_CELL_EN       = 1'h0;
   localparam rscpm_cfg_t    RST_CFG = '{RST_LITTLE_ENDIAN, RST_BOOT, RST_WCLK, RST_NCLK,
                                         RST_AUTOINIT, RST_CELL_EN};

   // Serial port 2 pin bundle toward the pads
   typedef struct packed {
      logic ext_clock_out;
      logic ext_clock_oe;
      logic tx_clock_out;
      logic tx_clock_oe;
      logic tx_data_out;
      logic tx_data_oe;
      logic rx_clock_out;
      logic rx_clock_oe;
      logic rx_frame_sync_out;
      logic rx_frame_sync_oe;
      logic tx_frame_sync_out;
      logic tx_frame_sync_oe;
   } rscpm_sp2_pads_t;

   localparam rscpm_sp2_pads_t RST_PADS = '0;

endpackage : rscpm_pkg

// ### rtl/rscpm_top.sv
`timescale 1ns/1ps
// Functional notes
// - Address pins drive half-word addresses normally, act as strap inputs in reset.
// - Strap at bit 20 picks byte order: 0 big, 1 little (default).
// - Boot field: 00 none, 01 host port, 10 8-bit ROM (default), 11 reserved.
// - Wide port clock: 00 external (default), 01 core/4, 10 core/6, 11 reserved.
// - Narrow port clock: same encoding, own field at bits 15:14.
// - Strap bit 13: 0 no EEPROM auto-init (default), 1 request it.
// - Strap bit 11: 0 serial port one owns shared pins, 1 cell port.
// - Peripheral enables come from serial port 2 pin combined with PCI pin.
// - PCI=1 and sp2 enable=0 disables sp2 and ties off its receive clock and frame syncs.
// - Ext clock source pin is input only unless software makes it GPIO 8.
// - Transmit clock pin serves sp2, or drives PROM clock under PCI.
// - Receive data pin serves sp2, or takes PROM data out under PCI.
// - Transmit data pin serves sp2, or drives PROM data in under PCI.
module rscpm_top
   import rscpm_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic                  ce,
   // Narrow memory port address pads
   input  wire logic [ADDR_W:1]       narrow_port_address_pins_in,
   input  wire logic [ADDR_W:1]       narrow_addr_core,
   input  wire logic                  narrow_addr_core_oe,
   output logic      [ADDR_W:1]       narrow_port_address_pins_out,
   output logic                       narrow_port_address_pins_oe,
   // Mode pins
   input  wire logic                  pci_enable_pin,
   input  wire logic                  serial_port2_enable_pin,
   // Captured configuration
   output rscpm_cfg_t                 cfg,
   output logic                       serial_port2_active,
   output logic                       prom_link_active,
   // Software GPIO 8 control
   input  wire logic                  gpio8_select,
   input  wire logic                  gpio8_dir_out,
   input  wire logic                  gpio8_data_out,
   output logic                       gpio_line_eight_in,
   // Serial port 2 core side
   input  wire logic                  sp2_tx_clock_core,
   input  wire logic                  sp2_tx_clock_core_oe,
   input  wire logic                  sp2_tx_data_core,
   input  wire logic                  sp2_tx_data_core_oe,
   input  wire logic                  sp2_rx_clock_core,
   input  wire logic                  sp2_rx_clock_core_oe,
   input  wire logic                  sp2_rx_fs_core,
   input  wire logic                  sp2_rx_fs_core_oe,
   input  wire logic                  sp2_tx_fs_core,
   input  wire logic                  sp2_tx_fs_core_oe,
   output logic                       sp2_rx_data_core,
   output logic                       sp2_ext_clock_source_core,
   // PROM serial link core side
   input  wire logic                  prom_serial_clock,
   input  wire logic                  prom_serial_data_in,
   output logic                       prom_serial_data_out,
   // Serial port 2 pads
   input  wire logic                  sp2_ext_clock_source_pin,
   input  wire logic                  sp2_rx_data_pin,
   output rscpm_sp2_pads_t            sp2_pads
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops, only stage two is read
   logic [ADDR_W:1] strap_s1_reg;
   logic [ADDR_W:1] strap_s2_reg;
   logic [3:0]      pin_s1_reg;
   logic [3:0]      pin_s2_reg;
   logic [3:0]      pin_raw;

   assign pin_raw = {pci_enable_pin, serial_port2_enable_pin,
                     sp2_ext_clock_source_pin, sp2_rx_data_pin};

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         strap_s1_reg <= narrow_port_address_pins_in;
         strap_s2_reg <= strap_s1_reg;
         pin_s1_reg   <= pin_raw;
         pin_s2_reg   <= pin_s1_reg;
      end
   end

   logic pci_en_s;
   logic sp2_en_s;
   logic ext_clk_s;
   logic rx_data_s;
   assign {pci_en_s, sp2_en_s, ext_clk_s, rx_data_s} = pin_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture; tracks straps during reset, frozen after release
   rscpm_cfg_t cfg_reg;
   rscpm_cfg_t cfg_next;
   logic       in_reset_reg;

   always_comb
   begin
      cfg_next = cfg_reg;
      if (in_reset_reg)
      begin
         cfg_next.little_endian            = strap_s2_reg[POS_ENDIAN];
         cfg_next.boot_mode                = rscpm_boot_t'(
            strap_s2_reg[POS_BOOT_HI:POS_BOOT_LO]);
         cfg_next.wide_port_clock_select   = rscpm_clksel_t'(
            strap_s2_reg[POS_WCLK_HI:POS_WCLK_LO]);
         cfg_next.narrow_port_clock_select = rscpm_clksel_t'(
            strap_s2_reg[POS_NCLK_HI:POS_NCLK_LO]);
         cfg_next.eeprom_autoinit          = strap_s2_reg[POS_AUTOINIT];
         cfg_next.cell_port_enable         = strap_s2_reg[POS_CELL_EN];
      end
   end

   // In reset the last sampled straps win; afterwards hold
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (srst)
         begin
            in_reset_reg <= 1'h1;
            cfg_reg      <= srst ? cfg_next : RST_CFG;
         end
         else
         begin
            in_reset_reg <= 1'h0;
            cfg_reg      <= cfg_next;
         end
      end
   end

   assign cfg = cfg_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address pad direction: inputs during reset, core drives after
   logic [ADDR_W:1] addr_out_reg;
   logic            addr_oe_reg;
   logic [ADDR_W:1] addr_out_next;
   logic            addr_oe_next;

   always_comb
   begin
      addr_out_next = narrow_addr_core;
      addr_oe_next  = narrow_addr_core_oe & ~srst;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         addr_out_reg <= '0;
         addr_oe_reg  <= 1'h0;
      end
      else if (ce)
      begin
         addr_out_reg <= addr_out_next;
         addr_oe_reg  <= addr_oe_next;
      end
   end

   assign narrow_port_address_pins_out = addr_out_reg;
   assign narrow_port_address_pins_oe  = addr_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial port 2 pin multiplexing
   rscpm_sp2_pads_t pads_reg;
   rscpm_sp2_pads_t pads_next;
   logic            sp2_act_reg;
   logic            sp2_act_next;
   logic            prom_act_reg;
   logic            prom_act_next;
   logic            rx_core_reg;
   logic            rx_core_next;
   logic            ext_core_reg;
   logic            ext_core_next;
   logic            gp8_in_reg;
   logic            gp8_in_next;
   logic            prom_do_reg;
   logic            prom_do_next;

   always_comb
   begin
      // Joint decode of both pins, never one alone
      sp2_act_next  = ~(pci_en_s & ~sp2_en_s);
      prom_act_next = pci_en_s & ~sp2_en_s;
      pads_next     = RST_PADS;
      rx_core_next  = 1'h0;
      prom_do_next  = 1'h0;
      ext_core_next = 1'h0;
      gp8_in_next   = 1'h0;
      if (gpio8_select)
      begin
         pads_next.ext_clock_out = gpio8_data_out;
         pads_next.ext_clock_oe  = gpio8_dir_out;
         gp8_in_next             = ext_clk_s;
      end
      else
         ext_core_next = ext_clk_s;
      if (prom_act_next)
      begin
         // Receive clock and frame syncs tied off: never driven
         pads_next.tx_clock_out = prom_serial_clock;
         pads_next.tx_clock_oe  = 1'h1;
         pads_next.tx_data_out  = prom_serial_data_in;
         pads_next.tx_data_oe   = 1'h1;
         prom_do_next           = rx_data_s;
      end
      else
      begin
         pads_next.tx_clock_out      = sp2_tx_clock_core;
         pads_next.tx_clock_oe       = sp2_tx_clock_core_oe;
         pads_next.tx_data_out       = sp2_tx_data_core;
         pads_next.tx_data_oe        = sp2_tx_data_core_oe;
         pads_next.rx_clock_out      = sp2_rx_clock_core;
         pads_next.rx_clock_oe       = sp2_rx_clock_core_oe;
         pads_next.rx_frame_sync_out = sp2_rx_fs_core;
         pads_next.rx_frame_sync_oe  = sp2_rx_fs_core_oe;
         pads_next.tx_frame_sync_out = sp2_tx_fs_core;
         pads_next.tx_frame_sync_oe  = sp2_tx_fs_core_oe;
         rx_core_next                = rx_data_s;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pads_reg     <= RST_PADS;
         sp2_act_reg  <= 1'h0;
         prom_act_reg <= 1'h0;
         rx_core_reg  <= 1'h0;
         ext_core_reg <= 1'h0;
         gp8_in_reg   <= 1'h0;
         prom_do_reg  <= 1'h0;
      end
      else if (ce)
      begin
         pads_reg     <= pads_next;
         sp2_act_reg  <= sp2_act_next;
         prom_act_reg <= prom_act_next;
         rx_core_reg  <= rx_core_next;
         ext_core_reg <= ext_core_next;
         gp8_in_reg   <= gp8_in_next;
         prom_do_reg  <= prom_do_next;
      end
   end

   assign sp2_pads                  = pads_reg;
   assign serial_port2_active       = sp2_act_reg;
   assign prom_link_active          = prom_act_reg;
   assign sp2_rx_data_core          = rx_core_reg;
   assign sp2_ext_clock_source_core = ext_core_reg;
   assign gpio_line_eight_in        = gp8_in_reg;
   assign prom_serial_data_out      = prom_do_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_ADDR_HIZ_IN_RESET: assert property (@(posedge clk)
      srst |=> !narrow_port_address_pins_oe)
      else $error("address pads driven during reset");
   AST_CFG_HOLD: assert property (@(posedge clk) disable iff (srst)
      (!srst && !$past(srst) && ce) |=> $stable(cfg))
      else $error("configuration changed after reset");
   // Two reset edges of history first: the synchroniser holds nothing known before that
   AST_ENDIAN_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.little_endian == $past(strap_s2_reg[POS_ENDIAN]))
      else $error("byte order strap not captured");
   AST_BOOT_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.boot_mode == $past(strap_s2_reg[POS_BOOT_HI:POS_BOOT_LO]))
      else $error("boot field not captured");
   AST_WCLK_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.wide_port_clock_select == $past(strap_s2_reg[POS_WCLK_HI:POS_WCLK_LO]))
      else $error("wide clock select not captured");
   AST_NCLK_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.narrow_port_clock_select == $past(strap_s2_reg[POS_NCLK_HI:POS_NCLK_LO]))
      else $error("narrow clock select not captured");
   AST_AUTOINIT_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.eeprom_autoinit == $past(strap_s2_reg[POS_AUTOINIT]))
      else $error("auto-init strap not captured");
   AST_CELL_CAPT: assert property (@(posedge clk)
      (srst && ce && $past(srst) && $past(srst, 2)) |=>
      cfg.cell_port_enable == $past(strap_s2_reg[POS_CELL_EN]))
      else $error("cell port strap not captured");
   AST_SP2_DISABLE: assert property (@(posedge clk) disable iff (srst)
      (ce && pci_en_s && !sp2_en_s) |=> (!sp2_pads.rx_clock_oe && !sp2_pads.rx_frame_sync_oe
      && !sp2_pads.tx_frame_sync_oe && prom_link_active && !serial_port2_active))
      else $error("serial port 2 not tied off");
   AST_PROM_MUX: assert property (@(posedge clk) disable iff (srst)
      (ce && prom_act_next) |=> (sp2_pads.tx_clock_oe && sp2_pads.tx_data_oe
      && sp2_pads.tx_data_out == $past(prom_serial_data_in)))
      else $error("PROM link not routed");
   AST_EXT_INPUT_ONLY: assert property (@(posedge clk) disable iff (srst)
      (ce && !gpio8_select) |=> !sp2_pads.ext_clock_oe)
      else $error("ext clock pin driven without GPIO select");
   COV_PROM: cover property (@(posedge clk) prom_link_active);
   COV_GPIO: cover property (@(posedge clk) sp2_pads.ext_clock_oe);
   COV_RELEASE: cover property (@(posedge clk) $fell(srst));

endmodule : rscpm_top

// ### tb/rscpm_board_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Board straps on the narrow port address pins plus a serial PROM on port 2
module rscpm_board_model
   import rscpm_pkg::*;
(
   input  wire logic            [ADDR_W:1] strap_value,
   input  wire logic                       pci_enable_pin,
   input  wire logic            [ADDR_W:1] addr_out,
   input  wire logic                       addr_oe,
   input  wire rscpm_sp2_pads_t            pads,
   input  wire logic                       link_on,
   output logic                 [ADDR_W:1] addr_pins,
   output logic                            rx_data_pin
);
   logic prom_bit_reg = 1'b0;

   // Resistors show only while the device leaves the bus undriven
   always_comb
   begin
      addr_pins = strap_value;
      if (!pci_enable_pin)
         addr_pins[POS_AUTOINIT] = 1'b0;  // Board keeps it low
      if (addr_oe)
         addr_pins = addr_out;
   end

   // PROM answers each received bit with its inverse
   always_ff @(posedge pads.tx_clock_out)
      prom_bit_reg <= ~pads.tx_data_out;

   // Pull-up holds the receive line when the PROM is not on the link
   assign rx_data_pin = link_on ? prom_bit_reg : 1'b1;
endmodule : rscpm_board_model

// ### tb/tb_reset_strap_config_pin_mux.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_reset_strap_config_pin_mux
   import rscpm_pkg::*;
;
   logic clk, srst, ce, aoe_core, pci, sp2_en, g_sel, g_dir, g_dat, ext_pin;
   logic txc, txc_oe, txd, txd_oe, rxc, rxc_oe, rfs, rfs_oe, tfs, tfs_oe, p_clk, p_din;
   logic [ADDR_W:1] straps, addr_core, pins_in, addr_out;
   logic addr_oe, sp2_act, prom_act, g_in, rxd_core, ext_core, p_dout, rx_pin;
   rscpm_cfg_t      cfg;
   rscpm_sp2_pads_t pads;
   int mismatches, checks_done;

   rscpm_top dut (.clk(clk), .srst(srst), .ce(ce), .narrow_port_address_pins_in(pins_in),
      .narrow_addr_core(addr_core), .narrow_addr_core_oe(aoe_core),
      .narrow_port_address_pins_out(addr_out), .narrow_port_address_pins_oe(addr_oe),
      .pci_enable_pin(pci), .serial_port2_enable_pin(sp2_en), .cfg(cfg),
      .serial_port2_active(sp2_act), .prom_link_active(prom_act), .gpio8_select(g_sel),
      .gpio8_dir_out(g_dir), .gpio8_data_out(g_dat), .gpio_line_eight_in(g_in),
      .sp2_tx_clock_core(txc), .sp2_tx_clock_core_oe(txc_oe), .sp2_tx_data_core(txd),
      .sp2_tx_data_core_oe(txd_oe), .sp2_rx_clock_core(rxc), .sp2_rx_clock_core_oe(rxc_oe),
      .sp2_rx_fs_core(rfs), .sp2_rx_fs_core_oe(rfs_oe), .sp2_tx_fs_core(tfs),
      .sp2_tx_fs_core_oe(tfs_oe), .sp2_rx_data_core(rxd_core),
      .sp2_ext_clock_source_core(ext_core), .prom_serial_clock(p_clk),
      .prom_serial_data_in(p_din), .prom_serial_data_out(p_dout),
      .sp2_ext_clock_source_pin(ext_pin), .sp2_rx_data_pin(rx_pin), .sp2_pads(pads));

   rscpm_board_model board (.strap_value(straps), .pci_enable_pin(pci), .addr_out(addr_out),
      .addr_oe(addr_oe), .pads(pads), .link_on(prom_act), .addr_pins(pins_in),
      .rx_data_pin(rx_pin));

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Reset long enough for the straps to pass the synchroniser
   task automatic reset_with(input logic [ADDR_W:1] s, input logic pc);
      cyc(1);
      straps <= s;
      pci    <= pc;
      srst   <= 1'b1;
      aoe_core <= 1'b1;  // Core asks to drive; pads must stay inputs
      cyc(6);
      chk(16'(addr_oe), 16'h0000);
      srst <= 1'b0;
      aoe_core <= 1'b0;
      cyc(2);
   endtask : reset_with

   // Every code of every field, reset after reset
   task automatic t_straps;
      logic [ADDR_W:1] s;
      logic [1:0]      b;
      for (int i = 0; i < 4; i++)
      begin
         b = 2'(i);
         s = 20'h5A5A5;
         s[20] = b[0];
         s[19:18] = b;
         s[17:16] = ~b;
         s[15:14] = b;
         s[13] = b[0];
         s[11] = b[1];
         reset_with(s, 1'b1);
         chk(16'(cfg), 16'({s[20], s[19:18], s[17:16], s[15:14], s[13], s[11]}));
      end
   endtask : t_straps

   // Pins move after release; the bus then carries core addresses
   task automatic t_hold;
      rscpm_cfg_t kept;
      kept = cfg;
      straps <= ~straps;
      cyc(6);
      chk(16'(cfg), 16'(kept));
      addr_core <= 20'hA5C3E;
      aoe_core  <= 1'b1;
      cyc(4);
      chk(16'(addr_out[16:1]), 16'h5C3E);
      chk(16'({addr_oe, addr_out[20:17]}), 16'h001A);
      chk(16'(cfg), 16'(kept));
      aoe_core <= 1'b0;
   endtask : t_hold

   // Auto-init strap with and without the PCI pin
   task automatic t_autoinit;
      logic [ADDR_W:1] s;
      s = '0;
      s[13] = 1'b1;
      reset_with(s, 1'b0);
      chk(16'(cfg.eeprom_autoinit), 16'h0000);
      reset_with(s, 1'b1);
      chk(16'(cfg.eeprom_autoinit), 16'h0001);
   endtask : t_autoinit

   // All four enable pin combinations, two data patterns each
   task automatic t_mux;
      logic [1:0] m;
      logic       v;
      for (int i = 0; i < 4; i++)
      begin
         m = 2'(i);
         for (int p = 0; p < 2; p++)
         begin
            v = p[0];
            {pci, sp2_en} <= m;
            {txc, txd, rxc, rfs, tfs} <= {5{v}};
            {p_clk, p_din} <= {2{~v}};
            // Two sync flops and the mode flop, then the pad line through two sync flops and its register
            cyc(7);
            chk(16'({prom_act, sp2_act}), (m == 2'h2) ? 16'h0002 : 16'h0001);
            if (m == 2'h2)
            begin
               chk(16'({pads.tx_clock_out, pads.tx_data_out}), {14'h0, ~v, ~v});
               chk(16'({pads.rx_clock_oe, pads.rx_frame_sync_oe, pads.tx_frame_sync_oe}), 16'h0000);
               chk(16'(p_dout), 16'(rx_pin));
            end
            else
            begin
               chk(16'({pads.tx_clock_out, pads.tx_data_out, pads.rx_clock_out,
                  pads.rx_frame_sync_out, pads.tx_frame_sync_out}), 16'({5{v}}));
               chk(16'(rxd_core), 16'(rx_pin));
            end
         end
      end
   endtask : t_mux

   // Clock source pin as plain input, GPIO input and GPIO output
   task automatic t_gpio;
      logic v;
      for (int p = 0; p < 2; p++)
      begin
         v = p[0];
         g_sel   <= 1'b0;
         ext_pin <= v;
         cyc(6);
         chk(16'({pads.ext_clock_oe, ext_core, g_in}), {14'h0, v, 1'b0});
         g_sel <= 1'b1;
         g_dir <= 1'b0;
         cyc(6);
         chk(16'({pads.ext_clock_oe, g_in}), 16'(v));
         g_dir <= 1'b1;
         g_dat <= ~v;
         cyc(6);
         chk(16'({pads.ext_clock_oe, pads.ext_clock_out}), {14'h0, 1'b1, ~v});
         g_dir <= 1'b0;
      end
      g_sel <= 1'b0;
   endtask : t_gpio

   // Main sequence
   initial
   begin
      {srst, ce, pci} = 3'b111;
      {aoe_core, sp2_en, g_sel, g_dir, g_dat, ext_pin} = '0;
      {txc, txc_oe, txd, txd_oe, rxc, rxc_oe, rfs, rfs_oe, tfs, tfs_oe} = 10'h155;
      {p_clk, p_din} = '0;
      straps = '0;
      addr_core = '0;
      mismatches = 0;
      checks_done = 0;
      cyc(6);
      srst <= 1'b0;
      t_straps();
      t_hold();
      t_autoinit();
      t_mux();
      t_gpio();
      end_sim();
   end

   // Watchdog well beyond the 162 cycles the tests need
   initial
   begin
      #100us;
      mismatches++;
      end_sim();
   end
endmodule : tb_reset_strap_config_pin_mux
